// >>> include/cid_pkg.sv
// Constants, opcode groups and types shared by the instruction decoder core.
package cid_pkg;
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned ICYC_CLKS     = 4;
   localparam int unsigned MIN_ICYC      = 1;
   localparam int unsigned MAX_ICYC      = 5;

   localparam logic [3:0] GRP_INC  = 4'h0;
   localparam logic [3:0] GRP_DEC  = 4'h1;
   localparam logic [3:0] GRP_ADD  = 4'h2;
   localparam logic [3:0] GRP_ADD_WITH_CARRY = 4'h3;
   localparam logic [3:0] GRP_OR   = 4'h4;
   localparam logic [3:0] GRP_AND  = 4'h5;
   localparam logic [3:0] GRP_XOR  = 4'h6;
   localparam logic [3:0] GRP_SUBTRACT_WITH_BORROW = 4'h9;

   localparam logic [3:0] LO_DIR_ACC = 4'h2;
   localparam logic [3:0] LO_DIR_IMM = 4'h3;
   localparam logic [3:0] LO_IMM     = 4'h4;
   localparam logic [3:0] LO_DIR     = 4'h5;
   localparam logic [2:0] LO_IND     = 3'h3;
   localparam logic [7:0] OPC_INC_DP = 8'ha3;
   localparam logic [7:0] OPC_AND_DI = 8'h53;
   localparam logic [7:0] OPC_OR_DI  = 8'h43;

   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;
   localparam logic [2:0] CYC_1 = 3'h1;
   localparam logic [2:0] CYC_2 = 3'h2;
   localparam logic [2:0] CYC_3 = 3'h3;

   localparam logic [15:0] PC_RST   = 16'h0000;
   localparam logic [15:0] DATA_POINTER_PAIR_RST = 16'h0000;
   localparam logic [7:0]  ACC_RST  = 8'h00;

   typedef enum logic [3:0] {
      OP_NOP   = 4'h0,
      OP_ADD   = 4'h1,
      OP_ADD_WITH_CARRY  = 4'h2,
      OP_SUBTRACT_WITH_BORROW  = 4'h3,
      OP_INC   = 4'h4,
      OP_DEC   = 4'h5,
      OP_AND   = 4'h6,
      OP_OR    = 4'h7,
      OP_XOR   = 4'h8,
      OP_INCDP = 4'h9
   } cid_op_t;

   typedef enum logic [2:0] {
      SRC_NONE = 3'h0,
      SRC_REG  = 3'h1,
      SRC_DIR  = 3'h2,
      SRC_IND  = 3'h3,
      SRC_IMM  = 3'h4,
      SRC_ACC  = 3'h5
   } cid_src_t;

   typedef enum logic [1:0] {
      PH_FETCH = 2'b00,
      PH_CAPT  = 2'b01,
      PH_ADDR  = 2'b10,
      PH_EXEC  = 2'b11
   } cid_phase_t;
endpackage

// >>> include/cid_dec_if.sv
// Opcode in, decoded operation and length out, between core and decoder.
interface cid_dec_if;
   logic [7:0]        opcode;
   cid_pkg::cid_op_t  op;
   cid_pkg::cid_src_t src;
   logic              to_mem;
   logic              imm2;
   logic [1:0]        nbytes;
   logic [2:0]        ncyc;
   logic [2:0]        rsel;

   modport dec  (input opcode, output op, src, to_mem, imm2, nbytes, ncyc,
                 rsel);
   modport core (output opcode, input op, src, to_mem, imm2, nbytes, ncyc,
                 rsel);
endinterface

// >>> verilog/cid_decoder.sv
// Combinational opcode decoder: operation, operand kind, length and cycles.
module cid_decoder (
   cid_dec_if.dec d
);
   logic [3:0] hi;
   logic [3:0] lo;
   logic       incdec;

   assign hi = d.opcode[7:4];
   assign lo = d.opcode[3:0];
   assign incdec = (hi == cid_pkg::GRP_INC) || (hi == cid_pkg::GRP_DEC);

   always_comb begin
      d.op     = cid_pkg::OP_NOP;
      d.src    = cid_pkg::SRC_NONE;
      d.to_mem = incdec;
      d.imm2   = 1'b0;
      d.nbytes = cid_pkg::LEN_1;
      d.ncyc   = cid_pkg::CYC_1;
      d.rsel   = d.opcode[2:0];
      unique case (hi)
         cid_pkg::GRP_ADD:  d.op = cid_pkg::OP_ADD;
         cid_pkg::GRP_ADD_WITH_CARRY: d.op = cid_pkg::OP_ADD_WITH_CARRY;
         cid_pkg::GRP_SUBTRACT_WITH_BORROW: d.op = cid_pkg::OP_SUBTRACT_WITH_BORROW;
         cid_pkg::GRP_INC:  d.op = cid_pkg::OP_INC;
         cid_pkg::GRP_DEC:  d.op = cid_pkg::OP_DEC;
         cid_pkg::GRP_AND:  d.op = cid_pkg::OP_AND;
         cid_pkg::GRP_OR:   d.op = cid_pkg::OP_OR;
         cid_pkg::GRP_XOR:  d.op = cid_pkg::OP_XOR;
         default:           d.op = cid_pkg::OP_NOP;
      endcase
      if (d.opcode == cid_pkg::OPC_INC_DP) begin
         d.op   = cid_pkg::OP_INCDP;
         d.ncyc = cid_pkg::CYC_3;
      end else if (d.op == cid_pkg::OP_NOP) begin
         d.to_mem = 1'b0;
      end else if (lo[3]) begin
         d.src = cid_pkg::SRC_REG;
      end else if (lo[3:1] == cid_pkg::LO_IND) begin
         d.src = cid_pkg::SRC_IND;
      end else if (lo == cid_pkg::LO_IMM) begin
         if (incdec) begin
            d.src = cid_pkg::SRC_ACC;
         end else begin
            d.src    = cid_pkg::SRC_IMM;
            d.nbytes = cid_pkg::LEN_2;
            d.ncyc   = cid_pkg::CYC_2;
         end
      end else if (lo == cid_pkg::LO_DIR) begin
         d.src    = cid_pkg::SRC_DIR;
         d.nbytes = cid_pkg::LEN_2;
         d.ncyc   = cid_pkg::CYC_2;
      end else if ((lo == cid_pkg::LO_DIR_ACC || lo == cid_pkg::LO_DIR_IMM)
                   && (d.op == cid_pkg::OP_AND || d.op == cid_pkg::OP_OR))
      begin
         d.src    = cid_pkg::SRC_DIR;
         d.to_mem = 1'b1;
         d.nbytes = cid_pkg::LEN_2;
         d.ncyc   = cid_pkg::CYC_2;
         if (lo == cid_pkg::LO_DIR_IMM) begin
            d.imm2   = 1'b1;
            d.nbytes = cid_pkg::LEN_3;
            d.ncyc   = cid_pkg::CYC_3;
         end
      end else begin
         d.op     = cid_pkg::OP_NOP;
         d.to_mem = 1'b0;
      end
   end
endmodule

// >>> verilog/cid_core.sv
// Four-clock instruction sequencer with fetch, operand access and execute.
module cid_core (
   // Clock and reset.
   input  wire logic        clk_sys_i,
   input  wire logic        arst_n_i,
   // Program memory.
   output logic [15:0]      pmem_addr_o,
   output logic             pmem_rd_o,
   input  wire logic [7:0]  pmem_data_i,
   // Data memory.
   output logic [7:0]       dmem_addr_o,
   output logic             dmem_rd_o,
   output logic             dmem_wr_o,
   output logic [7:0]       dmem_wdata_o,
   input  wire logic [7:0]  dmem_rdata_i,
   // Core state and operand targets.
   output logic [7:0]       acc_o,
   output logic             carry_o,
   output logic [15:0]      data_pointer_pair_o,
   output logic             instr_done_o,
   output logic [15:0]      rel_target_o,
   output logic [15:0]      abs_target_o,
   output logic [15:0]      long_target_o
);
   typedef struct packed {
      cid_pkg::cid_phase_t ph;
      logic [2:0]          icyc;
      logic [15:0]         pc;
      logic [7:0]          acc;
      logic                cy;
      logic [15:0]         data_pointer_pair;
      logic [7:0][7:0]     regs;
      logic [2:0][7:0]     ib;
      logic                pmem_rd;
      logic [7:0]          dmem_addr;
      logic                dmem_rd;
      logic                dmem_wr;
      logic [7:0]          dmem_wdata;
      logic                done;
      logic [15:0]         rel_tgt;
      logic [15:0]         abs_tgt;
      logic [15:0]         long_tgt;
   } cid_state_t;

   cid_state_t s_q;
   cid_state_t s_d;
   cid_dec_if  dec ();
   logic [7:0] opnd;
   logic [7:0] other;
   logic [8:0] sum;
   logic       last;

   cid_decoder u_dec (
      .d (dec.dec)
   );

   assign dec.opcode = s_q.ib[0];
   assign last = (s_q.icyc == 3'(dec.ncyc - 3'h1));

   always_comb begin
      unique case (dec.src)
         cid_pkg::SRC_REG: opnd = s_q.regs[dec.rsel];
         cid_pkg::SRC_IMM: opnd = s_q.ib[1];
         cid_pkg::SRC_ACC: opnd = s_q.acc;
         default:          opnd = dmem_rdata_i;
      endcase
      other = dec.imm2 ? s_q.ib[2] : s_q.acc;
      unique case (dec.op)
         cid_pkg::OP_ADD:  sum = {1'b0, other} + {1'b0, opnd};
         cid_pkg::OP_ADD_WITH_CARRY: sum = {1'b0, other} + {1'b0, opnd}
                                 + {8'h00, s_q.cy};
         cid_pkg::OP_SUBTRACT_WITH_BORROW: sum = {1'b0, other} - {1'b0, opnd}
                                 - {8'h00, s_q.cy};
         cid_pkg::OP_INC:  sum = {1'b0, 8'(opnd + 8'h01)};
         cid_pkg::OP_DEC:  sum = {1'b0, 8'(opnd - 8'h01)};
         cid_pkg::OP_AND:  sum = {1'b0, other & opnd};
         cid_pkg::OP_OR:   sum = {1'b0, other | opnd};
         cid_pkg::OP_XOR:  sum = {1'b0, other ^ opnd};
         default:          sum = {1'b0, s_q.acc};
      endcase
   end

   always_comb begin
      s_d         = s_q;
      s_d.done    = 1'b0;
      s_d.dmem_wr = 1'b0;
      s_d.ph      = cid_pkg::cid_phase_t'(2'(s_q.ph + 2'h1));
      unique case (s_q.ph)
         cid_pkg::PH_FETCH: begin
            // Opcode in cycle zero, then one operand byte per cycle.
            if (s_q.icyc == 3'h0 || s_q.icyc < {1'b0, dec.nbytes}) begin
               s_d.pmem_rd = 1'b1;
            end
         end
         cid_pkg::PH_CAPT: begin
            if (s_q.pmem_rd) begin
               s_d.ib[s_q.icyc[1:0]] = pmem_data_i;
               s_d.pc      = 16'(s_q.pc + 16'h0001);
               s_d.pmem_rd = 1'b0;
            end
         end
         cid_pkg::PH_ADDR: begin
            if (last && (dec.src == cid_pkg::SRC_DIR
                         || dec.src == cid_pkg::SRC_IND)) begin
               s_d.dmem_rd   = 1'b1;
               s_d.dmem_addr = (dec.src == cid_pkg::SRC_IND)
                               ? s_q.regs[{2'b00, dec.rsel[0]}]
                               : s_q.ib[1];
            end
         end
         cid_pkg::PH_EXEC: begin
            s_d.dmem_rd = 1'b0;
            s_d.icyc    = 3'(s_q.icyc + 3'h1);
            if (last) begin
               s_d.icyc = 3'h0;
               s_d.done = 1'b1;
               if (dec.op == cid_pkg::OP_INCDP) begin
                  s_d.data_pointer_pair = 16'(s_q.data_pointer_pair + 16'h0001);
               end else if (dec.op != cid_pkg::OP_NOP) begin
                  if (dec.op == cid_pkg::OP_ADD || dec.op == cid_pkg::OP_ADD_WITH_CARRY
                      || dec.op == cid_pkg::OP_SUBTRACT_WITH_BORROW) begin
                     s_d.cy = sum[8];
                  end
                  if (!dec.to_mem || dec.src == cid_pkg::SRC_ACC) begin
                     s_d.acc = sum[7:0];
                  end else if (dec.src == cid_pkg::SRC_REG) begin
                     s_d.regs[dec.rsel] = sum[7:0];
                  end else begin
                     s_d.dmem_wr    = 1'b1;
                     s_d.dmem_wdata = sum[7:0];
                  end
               end
               s_d.rel_tgt  = 16'(s_q.pc + {{8{s_q.ib[1][7]}}, s_q.ib[1]});
               s_d.abs_tgt  = {s_q.pc[15:11], s_q.ib[0][7:5], s_q.ib[1]};
               s_d.long_tgt = {s_q.ib[1], s_q.ib[2]};
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q      <= '0;
         s_q.ph   <= cid_pkg::PH_FETCH;
         s_q.pc   <= cid_pkg::PC_RST;
         s_q.acc  <= cid_pkg::ACC_RST;
         s_q.data_pointer_pair <= cid_pkg::DATA_POINTER_PAIR_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign pmem_addr_o   = s_q.pc;
   assign pmem_rd_o     = s_q.pmem_rd;
   assign dmem_addr_o   = s_q.dmem_addr;
   assign dmem_rd_o     = s_q.dmem_rd;
   assign dmem_wr_o     = s_q.dmem_wr;
   assign dmem_wdata_o  = s_q.dmem_wdata;
   assign acc_o         = s_q.acc;
   assign carry_o       = s_q.cy;
   assign data_pointer_pair_o        = s_q.data_pointer_pair;
   assign instr_done_o  = s_q.done;
   assign rel_target_o  = s_q.rel_tgt;
   assign abs_target_o  = s_q.abs_tgt;
   assign long_target_o = s_q.long_tgt;

   // Clocks since the previous completion and start address of the current one.
   // The count resets to all ones so the first clock after release is zero,
   // just as the clock after a completion is.
   logic [4:0]  clk_cnt_q;
   logic [15:0] pc_start_q;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clk_cnt_q  <= 5'h1f;
         pc_start_q <= cid_pkg::PC_RST;
      end else if (s_q.done) begin
         clk_cnt_q  <= 5'h00;
         pc_start_q <= s_q.pc;
      end else begin
         clk_cnt_q  <= 5'(clk_cnt_q + 5'h01);
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   property p_phase_wrap;
      s_q.ph == cid_pkg::PH_EXEC |=> s_q.ph == cid_pkg::PH_FETCH;
   endproperty
   a_phase_wrap: assert property (p_phase_wrap)
      else $error("phase did not wrap after execute");

   property p_done_spacing;
      s_q.done |=> !s_q.done [*3];
   endproperty
   a_done_spacing: assert property (p_done_spacing)
      else $error("completions closer than four clocks");

   property p_cyc_bounds;
      s_q.done |-> clk_cnt_q[1:0] == 2'h3 && clk_cnt_q <= 5'd19;
   endproperty
   a_cyc_bounds: assert property (p_cyc_bounds)
      else $error("instruction length not one to five cycles");

   property p_pc_advance;
      s_q.done |-> 16'(s_q.pc - pc_start_q) == {14'h0000, dec.nbytes};
   endproperty
   a_pc_advance: assert property (p_pc_advance)
      else $error("program counter did not advance by byte count");

   property p_data_pointer_pair_inc;
      s_q.done && dec.op == cid_pkg::OP_INCDP |-> clk_cnt_q == 5'd11
         && s_q.data_pointer_pair == 16'($past(s_q.data_pointer_pair, 4) + 16'h0001);
   endproperty
   a_data_pointer_pair_inc: assert property (p_data_pointer_pair_inc)
      else $error("data pointer increment wrong value or length");

   property p_reg_one_cycle;
      s_q.done && dec.src == cid_pkg::SRC_REG |-> clk_cnt_q == 5'd3;
   endproperty
   a_reg_one_cycle: assert property (p_reg_one_cycle)
      else $error("register operand instruction not one cycle");

   property p_dir_imm_three;
      s_q.done && (s_q.ib[0] == cid_pkg::OPC_AND_DI
                   || s_q.ib[0] == cid_pkg::OPC_OR_DI)
         |-> clk_cnt_q == 5'd11;
   endproperty
   a_dir_imm_three: assert property (p_dir_imm_three)
      else $error("immediate to direct not three cycles");

   property p_ind_addr;
      $rose(s_q.dmem_rd) && dec.src == cid_pkg::SRC_IND
         |-> s_q.dmem_addr == s_q.regs[{2'b00, s_q.ib[0][0]}];
   endproperty
   a_ind_addr: assert property (p_ind_addr)
      else $error("indirect address not taken from R0 or R1");
endmodule

// >>> verification/cid_mem_model.sv
// Program and data memory model that answers the core's fetch and operand
// strobes.
module cid_mem_model (
   // Clock.
   input  wire logic        clk_sys_i,
   // Program memory.
   input  wire logic [15:0] pmem_addr_i,
   input  wire logic        pmem_rd_i,
   output logic [7:0]       pmem_data_o,
   // Data memory.
   input  wire logic [7:0]  dmem_addr_i,
   input  wire logic        dmem_rd_i,
   input  wire logic        dmem_wr_i,
   input  wire logic [7:0]  dmem_wdata_i,
   output logic [7:0]       dmem_rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] prog_mem [256];
   logic [7:0] data_mem [256];
   logic [7:0] pmem_last = 8'h00;
   logic [7:0] dmem_last = 8'h00;

   // Outside a strobe the lines show the inverse of the last byte read, so
   // a core that samples late never sees a lucky match.
   assign pmem_data_o  = pmem_rd_i ? prog_mem[pmem_addr_i[7:0]] : ~pmem_last;
   assign dmem_rdata_o = dmem_rd_i ? data_mem[dmem_addr_i] : ~dmem_last;

   always @(posedge clk_sys_i) begin
      if (pmem_rd_i) pmem_last <= pmem_data_o;
      if (dmem_rd_i) dmem_last <= dmem_rdata_o;
      if (dmem_wr_i) data_mem[dmem_addr_i] <= dmem_wdata_i;
   end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the instruction sequencer and decoder.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys_i = 1'b0;
   logic        arst_n_i  = 1'b0;
   logic [15:0] pmem_addr_o;
   logic        pmem_rd_o;
   logic [7:0]  pmem_data_i;
   logic [7:0]  dmem_addr_o;
   logic        dmem_rd_o;
   logic        dmem_wr_o;
   logic [7:0]  dmem_wdata_o;
   logic [7:0]  dmem_rdata_i;
   logic [7:0]  acc_o;
   logic        carry_o;
   logic [15:0] data_pointer_pair_o;
   logic        instr_done_o;
   logic [15:0] rel_target_o;
   logic [15:0] abs_target_o;
   logic [15:0] long_target_o;
   int          num_errors = 0;
   int          compares   = 0;
   int          cycles     = 0;
   logic [15:0] exp_pc;
   logic        fresh;

   always #2.5 clk_sys_i = ~clk_sys_i;

   cid_core u_cid_core (
      .clk_sys_i    (clk_sys_i),    .arst_n_i     (arst_n_i),
      .pmem_addr_o  (pmem_addr_o),  .pmem_rd_o    (pmem_rd_o),
      .pmem_data_i  (pmem_data_i),  .dmem_addr_o  (dmem_addr_o),
      .dmem_rd_o    (dmem_rd_o),    .dmem_wr_o    (dmem_wr_o),
      .dmem_wdata_o (dmem_wdata_o), .dmem_rdata_i (dmem_rdata_i),
      .acc_o        (acc_o),        .carry_o      (carry_o),
      .data_pointer_pair_o       (data_pointer_pair_o),       .instr_done_o (instr_done_o),
      .rel_target_o (rel_target_o), .abs_target_o (abs_target_o),
      .long_target_o(long_target_o)
   );

   cid_mem_model u_cid_mem_model (
      .clk_sys_i   (clk_sys_i),   .pmem_addr_i (pmem_addr_o),
      .pmem_rd_i   (pmem_rd_o),   .pmem_data_o (pmem_data_i),
      .dmem_addr_i (dmem_addr_o), .dmem_rd_i   (dmem_rd_o),
      .dmem_wr_i   (dmem_wr_o),   .dmem_wdata_i(dmem_wdata_o),
      .dmem_rdata_o(dmem_rdata_i)
   );

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Lets the write strobe of the completed instruction land in the model.
   task automatic settle();
      @(posedge clk_sys_i);
      #1;
   endtask

   // Loads a program while the core is held in reset, then releases it.
   task automatic start(input logic [7:0] p[]);
      @(negedge clk_sys_i);
      arst_n_i = 1'b0;
      for (int i = 0; i < 256; i++) u_cid_mem_model.prog_mem[i] = 8'h00;
      foreach (p[i]) u_cid_mem_model.prog_mem[i] = p[i];
      repeat (16) @(negedge clk_sys_i);
      arst_n_i = 1'b1;
      exp_pc = 16'h0000;
      fresh = 1'b1;
   endtask

   // Waits for one completion and checks its spacing (the first after start only within 100 clocks) and the next fetch.
   task automatic step(input int n, input int len);
      int k;
      k = 0;
      do begin
         @(negedge clk_sys_i);
         k++;
      end while (instr_done_o !== 1'b1 && k < 100);
      exp_pc = exp_pc + 16'(len);
      if (!fresh) check(16'(k), 16'(4 * n));
      if (fresh) check(16'(k < 100), 16'h0001);
      fresh = 1'b0;
      check(pmem_addr_o, exp_pc);
      check({14'h0000, pmem_rd_o, dmem_rd_o}, 16'h0000);
   endtask

   task automatic test_arith();
      u_cid_mem_model.data_mem[8'h10] = 8'hfb;
      start('{8'h24, 8'h05, 8'h25, 8'h10, 8'h34, 8'h01, 8'h94, 8'h03,
              8'h95, 8'h10});
      step(2, 2); check(16'(acc_o), 16'h0005);
      step(2, 2); check({acc_o, 7'h00, carry_o}, 16'h0001);
      step(2, 2); check({acc_o, 7'h00, carry_o}, 16'h0200);
      step(2, 2); check({acc_o, 7'h00, carry_o}, 16'hff01);
      step(2, 2); check({acc_o, 7'h00, carry_o}, 16'h0300);
      $display("test_arith done");
   endtask

   task automatic test_incdec();
      u_cid_mem_model.data_mem[8'h01] = 8'h7f;
      u_cid_mem_model.data_mem[8'h02] = 8'h00;
      u_cid_mem_model.data_mem[8'h20] = 8'hff;
      u_cid_mem_model.data_mem[8'h21] = 8'h00;
      start('{8'h08, 8'h09, 8'h09, 8'h06, 8'h17, 8'h04, 8'h14, 8'h14,
              8'h05, 8'h20, 8'h15, 8'h21, 8'h0f, 8'h1f, 8'h1f, 8'h2f,
              8'h38, 8'h98});
      repeat (3) step(1, 1);
      step(1, 1);
      check({dmem_addr_o, dmem_wdata_o}, 16'h0180);
      check(16'(dmem_wr_o), 16'h0001);
      settle();
      check(16'(u_cid_mem_model.data_mem[1]), 16'h0080);
      step(1, 1);
      settle();
      check(16'(u_cid_mem_model.data_mem[2]), 16'h00ff);
      step(1, 1); check(16'(acc_o), 16'h0001);
      repeat (2) step(1, 1);
      check({acc_o, 7'h00, carry_o}, 16'hff00);
      step(2, 2);
      step(2, 2);
      settle();
      check(16'(u_cid_mem_model.data_mem[8'h20]), 16'h0000);
      check(16'(u_cid_mem_model.data_mem[8'h21]), 16'h00ff);
      repeat (3) step(1, 1);
      step(1, 1); check({acc_o, 7'h00, carry_o}, 16'hfe01);
      step(1, 1); check({acc_o, 7'h00, carry_o}, 16'h0001);
      step(1, 1); check({acc_o, 7'h00, carry_o}, 16'hfe01);
      $display("test_incdec done");
   endtask

   task automatic test_logic();
      u_cid_mem_model.data_mem[8'h10] = 8'hfb;
      u_cid_mem_model.data_mem[8'h30] = 8'haa;
      u_cid_mem_model.data_mem[8'h31] = 8'h00;
      u_cid_mem_model.data_mem[8'h01] = 8'h55;
      start('{8'h24, 8'hf0, 8'h44, 8'h0f, 8'h54, 8'h3c, 8'h65, 8'h10,
              8'h53, 8'h30, 8'h0f, 8'h43, 8'h30, 8'h50, 8'h52, 8'h30,
              8'h42, 8'h31, 8'h08, 8'h48, 8'h58, 8'h68, 8'h46});
      step(2, 2);
      step(2, 2); check(16'(acc_o), 16'h00ff);
      step(2, 2); check(16'(acc_o), 16'h003c);
      step(2, 2); check(16'(acc_o), 16'h00c7);
      step(3, 3);
      settle();
      check(16'(u_cid_mem_model.data_mem[8'h30]), 16'h000a);
      check(long_target_o, 16'h300f);
      check(abs_target_o, 16'h0230);
      check(rel_target_o, 16'h003b);
      step(3, 3);
      settle();
      check(16'(u_cid_mem_model.data_mem[8'h30]), 16'h005a);
      step(2, 2);
      settle();
      check(16'(u_cid_mem_model.data_mem[8'h30]), 16'h0042);
      step(2, 2);
      settle();
      check(16'(u_cid_mem_model.data_mem[8'h31]), 16'h00c7);
      step(1, 1);
      step(1, 1); check(16'(acc_o), 16'h00c7);
      step(1, 1); check(16'(acc_o), 16'h0001);
      step(1, 1); check(16'(acc_o), 16'h0000);
      step(1, 1); check(16'(acc_o), 16'h0055);
      $display("test_logic done");
   endtask

   task automatic test_data_pointer_pair();
      start('{8'ha3, 8'ha3, 8'h24, 8'hfe, 8'h00});
      step(3, 1); check(data_pointer_pair_o, 16'h0001);
      step(3, 1); check(data_pointer_pair_o, 16'h0002);
      step(2, 2); check(rel_target_o, 16'h0002);
      check(abs_target_o, 16'h01fe);
      step(1, 1);
      $display("test_data_pointer_pair done");
   endtask

   task automatic test_indirect();
      u_cid_mem_model.data_mem[8'h00] = 8'h03;
      u_cid_mem_model.data_mem[8'h40] = 8'hfb;
      start('{8'h24, 8'hfe, 8'h26, 8'h37, 8'h35, 8'h40, 8'h97, 8'h45,
              8'h40, 8'h55, 8'h40, 8'h57, 8'h36, 8'h96});
      step(2, 2);
      step(1, 1); check({acc_o, 7'h00, carry_o}, 16'h0101);
      step(1, 1); check({acc_o, 7'h00, carry_o}, 16'h0500);
      step(2, 2); check({acc_o, 7'h00, carry_o}, 16'h0001);
      step(1, 1); check({acc_o, 7'h00, carry_o}, 16'hfc01);
      step(2, 2); check({acc_o, 7'h00, carry_o}, 16'hff01);
      step(2, 2); check({acc_o, 7'h00, carry_o}, 16'hfb01);
      step(1, 1); check({acc_o, 7'h00, carry_o}, 16'h0301);
      step(1, 1); check({acc_o, 7'h00, carry_o}, 16'h0700);
      step(1, 1); check({acc_o, 7'h00, carry_o}, 16'h0400);
      $display("test_indirect done");
   endtask

   initial begin
      test_arith();
      test_incdec();
      test_logic();
      test_data_pointer_pair();
      test_indirect();
      test_done();
   end
endmodule
